// *** hdl/sto_gate_defs.vh ***
// constants for the safe torque off gating block
`ifndef SAFE_TORQUE_OFF_DEFS_VH
`define SAFE_TORQUE_OFF_DEFS_VH

// ----------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------
`define CLK_FREQ_HZ       50000000
`define FILTER_LEN        8
`define BRAKE_RESP_MS     30
`define NOBRAKE_RESP_MS   5
`define READY_DELAY_MS    400
`define READY_DELAY_CYC   ((`READY_DELAY_MS * (`CLK_FREQ_HZ / 1000)))
`define BRAKE_RESP_CYC    ((`BRAKE_RESP_MS * (`CLK_FREQ_HZ / 1000)))
`define NOBRAKE_RESP_CYC  ((`NOBRAKE_RESP_MS * (`CLK_FREQ_HZ / 1000)))

// ----------------------------------------------------------------------
// fault code bit positions (sub-codes .0 to .5)
// ----------------------------------------------------------------------
`define FLT_TRIGGER       0
`define FLT_MISMATCH      1
`define FLT_SUPPLY        2
`define FLT_INPUT_CKT     3
`define FLT_BUFFER_CKT    4
`define FLT_NOISE         5
`define FLT_WIDTH         6

`endif

// *** hdl/safe_torque_off_gate.v ***
// safe torque off gating, supervision and restart sequencing
//
// Contract
// - pwm passes only while both filtered requests are high.
// - with fault_on_trigger_select set, trigger logs fault; clears on release plus reset.
// - exactly one request low raises the mismatch fault.
// - logic supply over or under voltage forces torque off and supply fault.
// - input circuit, buffer circuit and noisy input faults force torque off.
// - braked motor: drive disabled within 30 ms of either request dropping.
// - unbraked motor: drive disabled within 5 ms of either request dropping.
// - monitor output active only when both requests are low.
// - monitor uses filtered requests; monitor active always blocks pwm.
// - pwm held off during power-on and until initialisation completes.
// - auto exit only with requests high, run command off, no dangerous fault.
// - any request restored high clears monitor immediately; servo ready stays off.
// - both restored: ready and operation after 400 ms, then pwm when commanded.
`timescale 1ns/10ps
`include "sto_gate_defs.vh"

module safe_torque_off_gate #(
  parameter FILTER_LEN      = `FILTER_LEN,
  parameter READY_DELAY_CYC = `READY_DELAY_CYC,
  parameter PWM_WIDTH       = 6
) (
  // clock, reset, enable
  input  wire                  sys_clk,
  input  wire                  rst,
  input  wire                  clk_en,
  // safety contacts
  input  wire                  torque_off_request_a,
  input  wire                  torque_off_request_b,
  // drive control
  input  wire                  init_done,
  input  wire                  servo_on_cmd,
  input  wire                  fault_on_trigger_select,
  input  wire                  fault_reset,
  input  wire [PWM_WIDTH-1:0]  pwm_in,
  // supervision inputs
  input  wire                  supply_5v_bad,
  input  wire                  input_ckt_bad,
  input  wire                  buffer_ckt_bad,
  // outputs
  output reg  [PWM_WIDTH-1:0]  pwm_out,
  output reg                   pwm_buffer_en,
  output reg                   safe_torque_off,
  output reg                   external_monitor_output,
  output reg                   servo_ready,
  output reg                   servo_running,
  output reg  [`FLT_WIDTH-1:0] fault_code
);

  localparam CW = 32;

  // sequencer state codes
  localparam [1:0] ST_INIT = 2'h0;
  localparam [1:0] ST_SAFE = 2'h1;
  localparam [1:0] ST_WAIT = 2'h2;
  localparam [1:0] ST_RUN  = 2'h3;

  // ----------------------------------------------------------------------
  // request filters
  // ----------------------------------------------------------------------
  wire [1:0] raw_req;
  reg  [1:0] sync1_q;
  reg  [1:0] sync2_q;
  reg  [1:0] filt_q;
  reg  [1:0] noisy_q;
  assign raw_req = {torque_off_request_b, torque_off_request_a};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
      reg [7:0] cnt_q;
      // two-stage sync then stable-count debounce
      always @(posedge sys_clk) begin
        if (rst) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
          filt_q[gi]  <= 1'b0;
          noisy_q[gi] <= 1'b0;
          cnt_q       <= 8'h00;
        end else if (clk_en) begin
          sync1_q[gi] <= raw_req[gi];
          sync2_q[gi] <= sync1_q[gi];
          noisy_q[gi] <= 1'b0;
          if (sync2_q[gi] == filt_q[gi]) begin
            cnt_q <= 8'h00;
          end else if (cnt_q >= FILTER_LEN[7:0] - 8'h01) begin
            filt_q[gi] <= sync2_q[gi];
            cnt_q      <= 8'h00;
          end else begin
            cnt_q <= cnt_q + 8'h01;
          end
          // input toggled back before settling: chatter
          if (sync2_q[gi] == filt_q[gi] && cnt_q != 8'h00) begin
            noisy_q[gi] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // filter priming
  // ----------------------------------------------------------------------
  // filters reset low while closed contacts idle high: without this the
  // monitor would report a false cut for a few cycles after every reset
  reg [1:0] fill_q;
  reg       primed_q;
  always @(posedge sys_clk) begin
    if (rst) begin
      fill_q   <= 2'h0;
      primed_q <= 1'b0;
    end else if (clk_en) begin
      fill_q <= {fill_q[0], 1'b1};
      if (fill_q[1] && sync2_q == filt_q) begin
        primed_q <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // combinational conditions
  // ----------------------------------------------------------------------
  wire both_high  = filt_q[0] & filt_q[1];
  wire both_low   = ~filt_q[0] & ~filt_q[1];
  wire mismatch   = filt_q[0] ^ filt_q[1];
  wire hw_fault   = supply_5v_bad | input_ckt_bad | buffer_ckt_bad | (|noisy_q);
  wire [`FLT_WIDTH-1:0] dangerous;
  reg  [1:0]     state_q;
  reg  [CW-1:0]  dly_q;
  reg            rst_edge_q;
  reg            init_q;
  wire           reset_rise = fault_reset & ~rst_edge_q;
  assign dangerous = fault_code & ~(`FLT_WIDTH'h01 << `FLT_TRIGGER);

  // ----------------------------------------------------------------------
  // fault latches: set wins over reset
  // ----------------------------------------------------------------------
  reg [`FLT_WIDTH-1:0] set_v;
  reg [`FLT_WIDTH-1:0] clr_v;
  always @* begin
    set_v = {`FLT_WIDTH{1'b0}};
    set_v[`FLT_TRIGGER]    = fault_on_trigger_select & ~both_high & init_q;
    set_v[`FLT_MISMATCH]   = mismatch;
    set_v[`FLT_SUPPLY]     = supply_5v_bad;
    set_v[`FLT_INPUT_CKT]  = input_ckt_bad;
    set_v[`FLT_BUFFER_CKT] = buffer_ckt_bad;
    set_v[`FLT_NOISE]      = |noisy_q;
    clr_v = {`FLT_WIDTH{1'b0}};
    // trigger fault clears only once both requests are withdrawn
    if (reset_rise) begin
      clr_v = {`FLT_WIDTH{1'b1}};
      clr_v[`FLT_TRIGGER] = both_high;
    end
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      fault_code <= {`FLT_WIDTH{1'b0}};
      rst_edge_q <= 1'b0;
    end else if (clk_en) begin
      rst_edge_q <= fault_reset;
      fault_code <= (fault_code & ~clr_v) | set_v;
    end
  end

  // ----------------------------------------------------------------------
  // sequencer: init, safe, restart wait, run
  // ----------------------------------------------------------------------
  reg [1:0] state_d;
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_INIT: if (init_q) state_d = ST_SAFE;
      ST_SAFE: begin
        // exit needs requests high, command off, no dangerous fault
        if (both_high && !servo_on_cmd && dangerous == {`FLT_WIDTH{1'b0}} &&
            !hw_fault && !set_v[`FLT_TRIGGER] && !fault_code[`FLT_TRIGGER]) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // any drop or live hardware fault restarts the wait from safe
        if (!both_high || hw_fault) state_d = ST_SAFE;
        else if (dly_q >= READY_DELAY_CYC - 1) state_d = ST_RUN;
      end
      ST_RUN: if (!both_high || hw_fault) state_d = ST_SAFE;
      default: state_d = ST_INIT;
    endcase
  end

  always @(posedge sys_clk) begin
    if (rst) begin
      state_q <= ST_INIT;
      dly_q   <= {CW{1'b0}};
      init_q  <= 1'b0;
    end else if (clk_en) begin
      init_q  <= init_done;
      state_q <= state_d;
      dly_q   <= (state_q == ST_WAIT && state_d == ST_WAIT) ? dly_q + 1'b1 : {CW{1'b0}};
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------------
  wire run_ok = (state_d == ST_RUN);
  always @(posedge sys_clk) begin
    if (rst) begin
      pwm_out                 <= {PWM_WIDTH{1'b0}};
      pwm_buffer_en           <= 1'b0;
      safe_torque_off         <= 1'b1;
      external_monitor_output <= 1'b0;
      servo_ready             <= 1'b0;
      servo_running           <= 1'b0;
    end else if (clk_en) begin
      external_monitor_output <= both_low & primed_q;
      servo_ready             <= run_ok;
      servo_running           <= run_ok & servo_on_cmd;
      safe_torque_off         <= ~run_ok;
      // gate requires both requests high, init done, no monitor
      pwm_buffer_en <= run_ok & both_high & init_q;
      pwm_out       <= (run_ok && both_high && init_q && servo_on_cmd) ?
                       pwm_in : {PWM_WIDTH{1'b0}};
    end
  end

endmodule

// *** verif/sto_gate_sva.sv ***
// assertions on the safe torque off gate ports
`timescale 1ns/10ps
module torque_off_checker #(
  parameter PWM_WIDTH = 6
) (
  // clock and reset
  input wire                 sys_clk,
  input wire                 rst,
  // inputs
  input wire                 torque_off_request_a,
  input wire                 torque_off_request_b,
  input wire                 init_done,
  input wire                 fault_on_trigger_select,
  input wire                 supply_5v_bad,
  // outputs
  input wire [PWM_WIDTH-1:0] pwm_out,
  input wire                 pwm_buffer_en,
  input wire                 safe_torque_off,
  input wire                 external_monitor_output,
  input wire                 servo_ready,
  input wire [5:0]           fault_code
);
  localparam int LAT = 12;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // a dropped request, then the blocked power stage
  sequence drop_s;
    $fell(torque_off_request_a) || $fell(torque_off_request_b);
  endsequence
  sequence safe_s;
    pwm_out == 0 && !pwm_buffer_en && safe_torque_off;
  endsequence
  a_drop_to_safe: assert property (drop_s |-> ##[1:LAT] safe_s)
    else $error("pwm not blocked after drop");
  a_monitor_blocks: assert property (external_monitor_output |-> pwm_out == 0)
    else $error("pwm with monitor active");
  a_monitor_off: assert property ((torque_off_request_a || torque_off_request_b)[*8]
    |-> !external_monitor_output) else $error("monitor with a request high");
  a_mismatch_flag: assert property ((torque_off_request_a != torque_off_request_b)[*8]
    |-> fault_code[1]) else $error("mismatch not flagged");
  a_supply_trip: assert property (supply_5v_bad |-> ##[0:6] fault_code[2] && safe_torque_off)
    else $error("supply fault not tripped");
  a_init_hold: assert property (!init_done |=> !pwm_buffer_en)
    else $error("buffer on before init");
  a_ready_delay: assert property ($rose(servo_ready) |-> $past(torque_off_request_a, 40)
    && $past(torque_off_request_b, 40)) else $error("ready too early");
  a_trigger_log: assert property (fault_on_trigger_select && $rose(safe_torque_off)
    |-> ##[0:2] fault_code[0]) else $error("trigger not logged");
endmodule
bind safe_torque_off_gate torque_off_checker #(.PWM_WIDTH(PWM_WIDTH)) torque_off_checker_inst (
  .sys_clk,
  .rst, .torque_off_request_a, .torque_off_request_b, .init_done, .fault_on_trigger_select,
  .supply_5v_bad, .pwm_out, .pwm_buffer_en, .safe_torque_off, .external_monitor_output,
  .servo_ready, .fault_code);

// *** verif/contact_pair.sv ***
// model of the dual channel safety contacts
`timescale 1ns/10ps
module contact_pair (
  // clock and commands
  input  wire  sys_clk,
  input  wire  open_a,
  input  wire  open_b,
  // contacts, high while closed
  output logic torque_off_request_a = 1'b1,
  output logic torque_off_request_b = 1'b1
);
  // both channels move on one edge so a paired opening stays consistent
  always @(posedge sys_clk) begin
    torque_off_request_a <= !open_a;
    torque_off_request_b <= !open_b;
  end
endmodule

// *** verif/tb.sv ***
// self-checking bench for the safe torque off gate
`timescale 1ns/10ps
module tb;
  logic       sys_clk, rst, clk_en, open_a, open_b, init_done, servo_on_cmd, fault_reset;
  logic       fault_on_trigger_select, supply_5v_bad, input_ckt_bad, buffer_ckt_bad;
  logic [5:0] pwm_in, pwm_out, fault_code;
  logic       torque_off_request_a, torque_off_request_b, pwm_buffer_en, safe_torque_off;
  logic       external_monitor_output, servo_ready, servo_running;
  int         num_errors, tests_run;
  contact_pair contact_pair_inst (.sys_clk, .open_a, .open_b, .torque_off_request_a,
    .torque_off_request_b);
  safe_torque_off_gate #(.FILTER_LEN(2), .READY_DELAY_CYC(50)) safe_torque_off_gate_inst (
    .sys_clk, .rst, .clk_en, .torque_off_request_a, .torque_off_request_b, .init_done,
    .servo_on_cmd, .fault_on_trigger_select, .fault_reset, .pwm_in, .supply_5v_bad,
    .input_ckt_bad, .buffer_ckt_bad, .pwm_out, .pwm_buffer_en, .safe_torque_off,
    .external_monitor_output, .servo_ready, .servo_running, .fault_code);
  task step(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task chk(input logic [5:0] exp, input logic [5:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask
  // fault reset pulse, then time for the restart delay
  task clear_faults;
    fault_reset = 1;
    step(2);
    fault_reset = 0;
    step(70);
  endtask
  task tally_and_finish;
    $display("tests_run=%0d num_errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    sys_clk = 0;
    forever #10 sys_clk = ~sys_clk;
  end
  // watchdog well past the expected run
  initial begin
    #100000;
    num_errors++;
    tally_and_finish;
  end
  initial begin
    {rst, open_a, open_b, init_done, servo_on_cmd, fault_reset} = 6'h20;
    {fault_on_trigger_select, supply_5v_bad, input_ckt_bad, buffer_ckt_bad} = 4'h0;
    clk_en = 1;
    pwm_in = 6'h2a;
    step(20);
    rst = 0;
    // filters still settling: the monitor must not report a cut
    step(3);
    chk(0, external_monitor_output);
    step(7);
    chk(0, pwm_buffer_en);
    init_done = 1;
    step(70);
    chk(1, servo_ready);
    chk(1, pwm_buffer_en);
    servo_on_cmd = 1;
    step(3);
    chk(6'h2a, pwm_out);
    chk(1, servo_running);
    open_a = 1;
    step(10);
    chk(0, pwm_out);
    chk(1, fault_code[1]);
    chk(0, external_monitor_output);
    open_b = 1;
    step(10);
    chk(1, external_monitor_output);
    {open_a, open_b} = 2'b00;
    step(10);
    chk(0, external_monitor_output);
    clear_faults;
    chk(0, servo_ready);
    servo_on_cmd = 0;
    step(70);
    chk(1, servo_ready);
    fault_on_trigger_select = 1;
    {open_a, open_b} = 2'b11;
    step(10);
    chk(6'h01, fault_code);
    {open_a, open_b} = 2'b00;
    step(10);
    chk(0, servo_ready);
    clear_faults;
    chk(1, servo_ready);
    fault_on_trigger_select = 0;
    // supply, input circuit and buffer circuit faults in turn
    for (int i = 0; i < 3; i++) begin
      {buffer_ckt_bad, input_ckt_bad, supply_5v_bad} = 3'b001 << i;
      step(8);
      chk(1, safe_torque_off);
      chk(6'h04 << i, fault_code);
      {buffer_ckt_bad, input_ckt_bad, supply_5v_bad} = 3'b000;
      clear_faults;
      chk(1, servo_ready);
    end
    // one-cycle chatter on channel a
    open_a = 1;
    step(1);
    open_a = 0;
    step(8);
    chk(6'h20, fault_code);
    chk(1, safe_torque_off);
    clear_faults;
    chk(1, servo_ready);
    // clock enable low holds the registered pwm_out
    servo_on_cmd = 1;
    step(3);
    chk(6'h2a, pwm_out);
    clk_en = 0;
    pwm_in = 6'h15;
    step(4);
    chk(6'h2a, pwm_out);
    clk_en = 1;
    step(2);
    chk(6'h15, pwm_out);
    tally_and_finish;
  end
endmodule
